// ---- srs_consts.svh ----
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH

// register offsets
`define SRS_ADDR_DENSITY   8'h62
`define SRS_ADDR_CONTROL   8'h63
`define SRS_ADDR_LIM_1UP   8'h64
`define SRS_ADDR_LIM_2DN   8'h65
`define SRS_ADDR_LIM_2UP   8'h66
`define SRS_ADDR_LIM_3DN   8'h67

// reset values
`define SRS_RST_DENSITY    8'h32
`define SRS_RST_CONTROL    8'h0E
`define SRS_RST_LIM_1UP    8'h08
`define SRS_RST_LIM_2DN    8'h06
`define SRS_RST_LIM_2UP    8'h40
`define SRS_RST_LIM_3DN    8'h08
`define SRS_RST_LIM_3UP    8'h48
`define SRS_RST_LIM_4DN    8'h0A
`define SRS_RST_LIM_4UP    8'h50
`define SRS_RST_LIM_5DN    8'h48

// field positions
`define SRS_DEN_WAKE_HI    7
`define SRS_DEN_WAKE_LO    4
`define SRS_DEN_WORK_HI    3
`define SRS_DEN_WORK_LO    0
`define SRS_CTL_AXIS       7
`define SRS_CTL_SCALE_HI   6
`define SRS_CTL_SCALE_LO   4
`define SRS_CTL_IVAL_HI    3
`define SRS_CTL_IVAL_LO    2
`define SRS_CTL_XLOW       1
`define SRS_CTL_XHIGH      0

// density codes and steps
`define SRS_CODE_MIN       4'h1
`define SRS_CODE_MAX       4'h5
`define SRS_CODE_LOW3      4'h2
`define SRS_BASE_STEPS     3'h3

// counts per inch: code 0, spacing of codes 1..5, and the value out of reset
`define SRS_CPI_CODE0      11'h07D
`define SRS_CPI_STEP       11'h0FA
`define SRS_CPI_RST        11'h1F4

// check interval timing
`define SRS_CLK_HZ         100000000
`define SRS_IVAL_UNIT_MS   4
`define SRS_IVAL_UNIT_CYC  ((`SRS_IVAL_UNIT_MS * `SRS_CLK_HZ) / 1000)

`endif

// ---- srs_pkg.sv ----
package srs_pkg;
    typedef logic [7:0]  srs_byte_t;
    typedef logic [3:0]  srs_code_t;
    typedef logic [10:0] srs_cpi_t;
    typedef logic [2:0]  srs_step_t;
endpackage

// ---- srs_switcher.sv ----
`timescale 1ns/1ps
`include "srs_consts.svh"

module srs_switcher #(
    parameter int               UNIT_CYCLES = `SRS_IVAL_UNIT_CYC,
    parameter srs_pkg::srs_byte_t LIM_3UP   = `SRS_RST_LIM_3UP,
    parameter srs_pkg::srs_byte_t LIM_4DN   = `SRS_RST_LIM_4DN,
    parameter srs_pkg::srs_byte_t LIM_4UP   = `SRS_RST_LIM_4UP,
    parameter srs_pkg::srs_byte_t LIM_5DN   = `SRS_RST_LIM_5DN
) (
    input  wire logic               ref_clk,
    input  wire logic               reset_n,
    input  wire logic [7:0]         reg_addr,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire srs_pkg::srs_byte_t reg_wdata,
    output srs_pkg::srs_byte_t      reg_rdata,
    output logic                    reg_rvalid,
    input  wire logic               speed_switch_enable,
    input  wire logic               rest_wake,
    input  wire srs_pkg::srs_byte_t velocity,
    output srs_pkg::srs_code_t      active_density_code,
    output srs_pkg::srs_cpi_t       counts_per_inch,
    output logic                    scale_axis_select,
    output logic [2:0]              axis_scale_factor,
    output logic                    check_tick
);
    import srs_pkg::*;

    srs_byte_t count_density_select;
    srs_byte_t speed_switch_control;
    srs_byte_t velocity_limit_1_up;
    srs_byte_t velocity_limit_2_down;
    srs_byte_t velocity_limit_2_up;
    srs_byte_t velocity_limit_3_down;
    srs_step_t step;
    srs_step_t next_step;
    srs_code_t next_code;
    logic [21:0] unit_cnt;
    logic [1:0]  unit_idx;
    srs_byte_t   lim_up [4];
    srs_byte_t   lim_dn [4];

    // code to counts per inch; unlisted codes give zero
    // code 0 is the odd one out, codes 1..5 sit one fixed spacing apart
    function automatic srs_cpi_t srs_cpi(input srs_code_t code);
        srs_cpi_t r;
        r = 11'h000;
        if (code == 4'h0) begin
            r = `SRS_CPI_CODE0;
        end else if (code <= `SRS_CODE_MAX) begin
            r = 11'({7'h00, code} * `SRS_CPI_STEP);
        end
        return r;
    endfunction

    // fields of the control and density registers
    wire logic       xlow  = speed_switch_control[`SRS_CTL_XLOW];
    wire logic       xhigh = speed_switch_control[`SRS_CTL_XHIGH];
    wire logic [1:0] ival  = speed_switch_control[`SRS_CTL_IVAL_HI:`SRS_CTL_IVAL_LO];
    wire srs_code_t  work  = count_density_select[`SRS_DEN_WORK_HI:`SRS_DEN_WORK_LO];
    wire srs_code_t  wake  = count_density_select[`SRS_DEN_WAKE_HI:`SRS_DEN_WAKE_LO];

    // number of enabled steps and the code of the lowest one
    wire srs_step_t  n_steps = `SRS_BASE_STEPS + {2'b00, xlow} + {2'b00, xhigh};
    wire srs_step_t  top     = n_steps - 3'h1;
    wire srs_code_t  base    = xlow ? `SRS_CODE_MIN : `SRS_CODE_LOW3;

    // limits ordered by step; the upper four come from parameters
    assign lim_up[0] = velocity_limit_1_up;
    assign lim_up[1] = velocity_limit_2_up;
    assign lim_up[2] = LIM_3UP;
    assign lim_up[3] = LIM_4UP;
    assign lim_dn[0] = velocity_limit_2_down;
    assign lim_dn[1] = velocity_limit_3_down;
    assign lim_dn[2] = LIM_4DN;
    assign lim_dn[3] = LIM_5DN;

    // register writes; the working code is stored even while switching
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_density_select  <= `SRS_RST_DENSITY;
            speed_switch_control  <= `SRS_RST_CONTROL;
            velocity_limit_1_up   <= `SRS_RST_LIM_1UP;
            velocity_limit_2_down <= `SRS_RST_LIM_2DN;
            velocity_limit_2_up   <= `SRS_RST_LIM_2UP;
            velocity_limit_3_down <= `SRS_RST_LIM_3DN;
        end else if (reg_wr) begin
            if (reg_addr == `SRS_ADDR_DENSITY) begin
                count_density_select <= reg_wdata;
            end else if (reg_addr == `SRS_ADDR_CONTROL) begin
                speed_switch_control <= reg_wdata;
            end else if (reg_addr == `SRS_ADDR_LIM_1UP) begin
                velocity_limit_1_up <= reg_wdata;
            end else if (reg_addr == `SRS_ADDR_LIM_2DN) begin
                velocity_limit_2_down <= reg_wdata;
            end else if (reg_addr == `SRS_ADDR_LIM_2UP) begin
                velocity_limit_2_up <= reg_wdata;
            end else if (reg_addr == `SRS_ADDR_LIM_3DN) begin
                velocity_limit_3_down <= reg_wdata;
            end
        end
    end

    // register reads answer one cycle later; unmapped reads give zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (!reg_rd) begin
                reg_rdata <= 8'h00;
            end else if (reg_addr == `SRS_ADDR_DENSITY) begin
                reg_rdata <= {wake, active_density_code};
            end else if (reg_addr == `SRS_ADDR_CONTROL) begin
                reg_rdata <= speed_switch_control;
            end else if (reg_addr == `SRS_ADDR_LIM_1UP) begin
                reg_rdata <= velocity_limit_1_up;
            end else if (reg_addr == `SRS_ADDR_LIM_2DN) begin
                reg_rdata <= velocity_limit_2_down;
            end else if (reg_addr == `SRS_ADDR_LIM_2UP) begin
                reg_rdata <= velocity_limit_2_up;
            end else if (reg_addr == `SRS_ADDR_LIM_3DN) begin
                reg_rdata <= velocity_limit_3_down;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // interval timer: count 4 ms units, tick after (ival+1) of them
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            unit_cnt   <= 22'h000000;
            unit_idx   <= 2'h0;
            check_tick <= 1'b0;
        end else begin
            check_tick <= 1'b0;
            if (unit_cnt == 22'(UNIT_CYCLES - 1)) begin
                unit_cnt <= 22'h000000;
                if (unit_idx >= ival) begin
                    unit_idx   <= 2'h0;
                    check_tick <= 1'b1;
                end else begin
                    unit_idx <= unit_idx + 2'h1;
                end
            end else begin
                unit_cnt <= unit_cnt + 22'h000001;
            end
        end
    end

    // step choice; a wake beats a tick, and a shrunk range clamps the step
    always_comb begin
        next_step = (step > top) ? top : step;
        if (speed_switch_enable && rest_wake) begin
            if (wake <= base) begin
                next_step = 3'h0;
            end else if (wake - base > {1'b0, top}) begin
                next_step = top;
            end else begin
                next_step = 3'(wake - base);
            end
        end else if (speed_switch_enable && check_tick) begin
            if (next_step < top && velocity > lim_up[next_step[1:0]]) begin
                next_step = next_step + 3'h1;
            end else if (next_step != 3'h0 && velocity < lim_dn[next_step[1:0] - 2'h1]) begin
                next_step = next_step - 3'h1;
            end
        end
    end

    // active code: fixed work code when off, else step above base
    always_comb begin
        if (speed_switch_enable) begin
            next_code = base + {1'b0, next_step};
        end else begin
            next_code = work;
        end
    end

    // step and outputs; all drive straight from flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            step                <= 3'h0;
            active_density_code <= `SRS_CODE_LOW3;
            counts_per_inch     <= `SRS_CPI_RST;
        end else begin
            step                <= next_step;
            active_density_code <= next_code;
            counts_per_inch     <= srs_cpi(next_code);
        end
    end

    // scaling selection mirrors the control register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            scale_axis_select <= 1'b0;
            axis_scale_factor <= 3'h0;
        end else begin
            scale_axis_select <= speed_switch_control[`SRS_CTL_AXIS];
            axis_scale_factor <= speed_switch_control[`SRS_CTL_SCALE_HI:`SRS_CTL_SCALE_LO];
        end
    end

    // helper: cycles since last tick, valid while the interval is unchanged
    logic [22:0] gap;
    logic        gap_ok;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap    <= 23'h000000;
            gap_ok <= 1'b0;
        end else begin
            gap    <= check_tick ? 23'h000001 : gap + 23'h000001;
            gap_ok <= check_tick ? 1'b1 : gap_ok && !(reg_wr && reg_addr == `SRS_ADDR_CONTROL);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    AST_CPI_MAP: assert property (
        counts_per_inch == srs_cpi(active_density_code))
        else $error("cpi does not match density code");
    AST_WAKE: assert property (
        speed_switch_enable && rest_wake && xlow && xhigh && wake >= 4'h1 && wake <= 4'h5
        |=> !speed_switch_enable || active_density_code == $past(wake))
        else $error("wake code not adopted");
    AST_RANGE: assert property (
        speed_switch_enable && $past(speed_switch_enable) && xlow && xhigh
        |-> active_density_code >= 4'h1 && active_density_code <= 4'h5)
        else $error("active code outside 250..1250");
    AST_READBACK: assert property (
        reg_rd && reg_addr == `SRS_ADDR_DENSITY
        |=> reg_rvalid && reg_rdata[3:0] == $past(active_density_code))
        else $error("density readback wrong");
    AST_FIXED: assert property (
        !speed_switch_enable |=> active_density_code == $past(work))
        else $error("fixed code not kept");
    AST_SCALE: assert property (
        reg_wr && reg_addr == `SRS_ADDR_CONTROL
        |=> ##1 scale_axis_select == $past(reg_wdata[7], 2)
        && axis_scale_factor == $past(reg_wdata[6:4], 2))
        else $error("scale fields not applied");
    AST_INTERVAL: assert property (
        check_tick && gap_ok |-> gap == 23'(({21'h0, ival} + 23'h1) * 23'(UNIT_CYCLES)))
        else $error("check interval wrong");
    AST_STEP_TOP: assert property (
        $past(speed_switch_enable) |-> step <= $past(top))
        else $error("step beyond enabled range");
    AST_UP: assert property (
        speed_switch_enable && !rest_wake && check_tick && step < top
        && velocity > lim_up[step[1:0]] |=> step == $past(step) + 3'h1)
        else $error("no step up over limit");
    // up wins when limits overlap, so a step down is owed only when no step up is
    AST_DOWN: assert property (
        speed_switch_enable && !rest_wake && check_tick && step != 3'h0 && step <= top
        && !(step < top && velocity > lim_up[step[1:0]])
        && velocity < lim_dn[step[1:0] - 2'h1] |=> step == $past(step) - 3'h1)
        else $error("no step down under limit");
    AST_UP_2: assert property (
        speed_switch_enable && !rest_wake && check_tick && step == 3'h1
        && velocity > velocity_limit_2_up |=> step == 3'h2)
        else $error("no move from step 2 to 3");
    AST_DOWN_3: assert property (
        speed_switch_enable && !rest_wake && check_tick && step == 3'h2 && step <= top
        && !(step < top && velocity > lim_up[2]) && velocity < velocity_limit_3_down
        |=> step == 3'h1)
        else $error("no move from step 3 to 2");
    // without a tick or a wake the step must not drift
    AST_HOLD: assert property (
        speed_switch_enable && !rest_wake && !check_tick && step <= top
        |=> step == $past(step))
        else $error("step moved without a tick");
    AST_TICK_PULSE: assert property (
        check_tick |=> !check_tick)
        else $error("check tick longer than one cycle");
    AST_RVALID: assert property (
        !reg_rd |=> !reg_rvalid)
        else $error("read answer without a read");
    // fixed points of the cpi table, independent of the map function
    AST_CPI_LOW: assert property (
        active_density_code == 4'h0 |-> counts_per_inch == 11'h07D)
        else $error("code 0 not at 125 cpi");
    AST_CPI_MID: assert property (
        active_density_code == 4'h3 |-> counts_per_inch == 11'h2EE)
        else $error("code 3 not at 750 cpi");
    AST_CPI_HIGH: assert property (
        active_density_code == 4'h5 |-> counts_per_inch == 11'h4E2)
        else $error("code 5 not at 1250 cpi");

    COV_WAKE: cover property (speed_switch_enable && rest_wake);
    COV_TOP: cover property (speed_switch_enable && active_density_code == 4'h5);
    COV_BOTTOM: cover property (speed_switch_enable && active_density_code == 4'h1);
    COV_READ: cover property (reg_rvalid && speed_switch_enable);
    COV_FIXED: cover property (!speed_switch_enable && reg_wr && reg_addr == `SRS_ADDR_DENSITY);

endmodule // srs_switcher

// ---- srs_host_model.sv ----
`timescale 1ns/1ps
// host side of the register port: one strobe per access, address and data held meanwhile
module srs_host_model (
    input  wire logic               ref_clk,
    output logic [7:0]              reg_addr,
    output logic                    reg_wr,
    output logic                    reg_rd,
    output srs_pkg::srs_byte_t      reg_wdata,
    input  wire srs_pkg::srs_byte_t reg_rdata,
    input  wire logic               reg_rvalid
);
    import srs_pkg::*;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input srs_byte_t d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // thresholds are written as velocity times eight
    task automatic wr_ips(input logic [7:0] a, input logic [4:0] ips);
        wr(a, {ips, 3'b000});
    endtask
    // answer is taken at the edge where reg_rvalid is sampled high
    task automatic rd(input logic [7:0] a, output srs_byte_t d, output logic v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge ref_clk);
        d = reg_rdata;
        v = reg_rvalid;
    endtask
endmodule // srs_host_model

// ---- speed_resolution_switcher_tb.sv ----
`timescale 1ns/1ps
module speed_resolution_switcher_tb;
    import srs_pkg::*;
    logic       ref_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic [7:0] reg_addr;
    logic       reg_wr, reg_rd, reg_rvalid, scale_axis_select, check_tick, rd_v;
    logic       speed_switch_enable = 1'b0;
    logic       rest_wake = 1'b0;
    logic       track = 1'b0;
    logic       live = 1'b0;
    srs_byte_t  reg_wdata, reg_rdata, rd_d, v;
    srs_byte_t  velocity = 8'h00;
    srs_byte_t  lim_up[4] = '{8'h08, 8'h40, 8'h48, 8'h50};
    srs_byte_t  lim_dn[4] = '{8'h06, 8'h08, 8'h0A, 8'h48};
    srs_byte_t  rst_val[6] = '{8'h32, 8'h0E, 8'h08, 8'h06, 8'h40, 8'h08};
    srs_code_t  active_density_code, wake;
    srs_cpi_t   counts_per_inch;
    logic [2:0] axis_scale_factor;
    int         fail_count = 0, cmp_count = 0, seed = 47, n, step = 0, base = 2, nst = 3;
    always #5 ref_clk = ~ref_clk;
    srs_switcher #(.UNIT_CYCLES(20)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .speed_switch_enable(speed_switch_enable),
        .rest_wake(rest_wake), .velocity(velocity), .active_density_code(active_density_code),
        .counts_per_inch(counts_per_inch), .scale_axis_select(scale_axis_select),
        .axis_scale_factor(axis_scale_factor), .check_tick(check_tick));
    srs_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // density code to counts per inch, unknown codes give zero
    function automatic srs_cpi_t exp_cpi(input srs_code_t c);
        case (c)
            4'h0: return 11'd125;
            4'h1: return 11'd250;
            4'h2: return 11'd500;
            4'h3: return 11'd750;
            4'h4: return 11'd1000;
            4'h5: return 11'd1250;
            default: return 11'd0;
        endcase
    endfunction
    task automatic wait_tick(output int k);
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (check_tick !== 1'b1 && k < 300);
        // a tick that never comes counts as a mismatch
        if (check_tick !== 1'b1) fail_count++;
    endtask
    // reference step tracker, sampled with the same pre-edge values the design sees
    always @(posedge ref_clk) begin
        live = track && speed_switch_enable;
        if (live && rest_wake)
            step = (wake < base) ? 0 : ((wake - base > nst - 1) ? nst - 1 : wake - base);
        else if (live && check_tick && step < nst - 1 && velocity > lim_up[step])
            step = step + 1;
        else if (live && check_tick && step > 0 && velocity < lim_dn[step-1])
            step = step - 1;
    end
    // compare every settled cycle while switching is live
    always @(negedge ref_clk) begin
        if (live) begin
            check(active_density_code, base + step);
            check(counts_per_inch, exp_cpi(base + step));
        end
    end
    initial begin
        #200000;
        fail_count++;
        complete_run;
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        check(counts_per_inch, 11'd500);
        for (int a = 0; a < 6; a++) begin
            host.rd(8'h62 + a[7:0], rd_d, rd_v);
            check({rd_v, rd_d}, {1'b1, rst_val[a]});
        end
        host.rd(8'h70, rd_d, rd_v);
        check({rd_v, rd_d}, 9'h100);
        // fixed density: every legal code, switching off
        for (int c = 0; c < 6; c++) begin
            host.wr(8'h62, {4'h3, c[3:0]});
            // register lands at the write edge, the active code one edge later
            repeat (2) @(negedge ref_clk);
            check({active_density_code, counts_per_inch}, {c[3:0], exp_cpi(c[3:0])});
            host.rd(8'h62, rd_d, rd_v);
            check(rd_d, {4'h3, c[3:0]});
        end
        // wake and ticks are ignored while switching is off
        rest_wake <= 1'b1;
        @(posedge ref_clk);
        rest_wake <= 1'b0;
        wait_tick(n);
        @(negedge ref_clk);
        check(active_density_code, 4'h5);
        for (int f = 0; f < 8; f++) begin
            v = $random(seed);
            host.wr(8'h63, {v[0], f[2:0], 4'hE});
            repeat (2) @(negedge ref_clk);
            check({scale_axis_select, axis_scale_factor}, {v[0], f[2:0]});
        end
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h63, {4'h0, i[1:0], 2'b10});
            wait_tick(n);
            wait_tick(n);
            wait_tick(n);
            check(n, (i + 1) * 20);
        end
        // automatic stepping for each extra-step combination, random limits after the first
        for (int c = 0; c < 4; c++) begin
            host.wr(8'h63, {6'h00, c[1:0]});
            base = c[1] ? 1 : 2;
            nst = 3 + c[1] + c[0];
            wake = $unsigned($random(seed)) % 6;
            host.wr(8'h62, {wake, 4'h2});
            for (int a = 0; a < 4 && c > 0; a++) begin
                v = $random(seed);
                host.wr_ips(8'h64 + a[7:0], v[4:0]);
                if (a[0]) lim_dn[a/2] = {v[4:0], 3'b000};
                else lim_up[a/2] = {v[4:0], 3'b000};
            end
            track = 1'b1;
            speed_switch_enable <= 1'b1;
            rest_wake <= 1'b1;
            for (int k = 0; k < 400; k++) begin
                @(posedge ref_clk);
                v = $random(seed);
                rest_wake <= (v[7:0] < 8'h04);
                v = $random(seed);
                velocity <= v[7] ? v : (v[4] ? lim_up[v[1:0]] : lim_dn[v[1:0]]) + v[3:2] - 8'h1;
            end
            // let the last random wake stand one cycle before dropping it
            @(posedge ref_clk);
            rest_wake <= 1'b0;
            wait_tick(n);
            host.rd(8'h62, rd_d, rd_v);
            check(rd_d, {wake, 4'(base + step)});
            speed_switch_enable <= 1'b0;
            track = 1'b0;
            repeat (3) @(negedge ref_clk);
            check(active_density_code, 4'h2);
        end
        complete_run;
    end
endmodule // speed_resolution_switcher_tb
